// ---- mlk_pkg.sv ----
`default_nettype none
package mlk_pkg;
  localparam int LANES = 4;
  localparam int SKEW_SYMS = 2;
  localparam int DESKEW_DEPTH = SKEW_SYMS * (LANES - 1);
  localparam int SYNC_STAGES = 3;
  // control codes of the link alphabet, neutral values
  localparam logic [7:0] SYM_BS = 8'h01;
  localparam logic [7:0] SYM_BE = 8'h02;
  localparam logic [7:0] SYM_SS = 8'h03;
  localparam logic [7:0] SYM_SE = 8'h04;
  localparam logic [7:0] SYM_FS = 8'h05;
  localparam logic [7:0] SYM_FE = 8'h06;
  localparam int MN_W = 24;
  localparam logic [MN_W-1:0] N_ASYNC = 24'h008000;
  localparam int MN_SHIFT_W = 4;
  localparam int ACC_W = MN_W + 2;
  // attribute byte rows after the second start symbol
  localparam logic [3:0] ATTR_MVID_HI = 4'h0;
  localparam logic [3:0] ATTR_MVID_MID = 4'h1;
  localparam logic [3:0] ATTR_MVID_LO = 4'h2;
  localparam logic [3:0] ATTR_NVID_HI = 4'h3;
  localparam logic [3:0] ATTR_NVID_MID = 4'h4;
  localparam logic [3:0] ATTR_NVID_LO = 4'h5;
  localparam logic [3:0] ATTR_MISC = 4'h6;
  localparam logic [3:0] ATTR_LEN = 4'h9;
  localparam int NVID_LANE = 3;
  localparam int MISC_SYNC_BIT = 0;
  localparam int MISC_FMT_LSB = 1;
  localparam int MISC_DEPTH_LSB = 5;
  localparam logic [1:0] FMT_RGB = 2'h0;
  localparam logic [2:0] DEPTH_8BPC = 3'h1;
  localparam logic [7:0] MISC_RESET = 8'h20;
  localparam int RS_N = 15;
  localparam int RS_K = 13;
  localparam int RS_SYM_W = 4;
  localparam logic [3:0] GF_POLY_LOW = 4'h3;
  localparam logic [3:0] GF_ALPHA = 4'h2;

  typedef struct packed {
    logic isCtrl;
    logic [7:0] data;
  } mlk_sym_t;
  typedef mlk_sym_t [LANES-1:0] mlk_lanes_t;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } mlk_pix_t;
  typedef mlk_pix_t [LANES-1:0] mlk_pixels_t;
  typedef struct packed {
    logic [MN_W-1:0] mvid;
    logic [MN_W-1:0] nvid;
    logic [7:0] misc;
  } mlk_attr_t;

  // bitwise vote; a 2:2 tie and fewer than four lanes fall back to lane 0
  function automatic logic [7:0] mlk_vote(input mlk_lanes_t l, input logic [2:0] n);
    logic [7:0] v;
    logic [2:0] ones;
    v = l[0].data;
    if (n == 3'h4) begin
      for (int b = 0; b < 8; b++) begin
        ones = 3'({2'b0, l[0].data[b]} + {2'b0, l[1].data[b]} + {2'b0, l[2].data[b]}
               + {2'b0, l[3].data[b]});
        v[b] = (ones >= 3'h3) ? 1'b1 : ((ones == 3'h2) ? l[0].data[b] : 1'b0);
      end
    end
    return v;
  endfunction
endpackage
`default_nettype wire

// ---- mlk_rs_dec.sv ----
`default_nettype none
module mlk_rs_dec
  import mlk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic symValid,
  input wire logic [RS_SYM_W-1:0] sym,
  input wire logic flush,
  output logic wordValid,
  output logic [RS_K*RS_SYM_W-1:0] wordData,
  output logic corrected,
  output logic uncorrectable
);
  function automatic logic [3:0] gfMul(input logic [3:0] a, input logic [3:0] b);
    logic [3:0] p;
    logic [3:0] t;
    p = 4'h0;
    t = a;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) p = p ^ t;
      t = t[3] ? ({t[2:0], 1'b0} ^ GF_POLY_LOW) : {t[2:0], 1'b0};
    end
    return p;
  endfunction

  logic [3:0] sym_r [RS_N];
  logic [3:0] cnt_r;
  logic [3:0] s0_r;
  logic [3:0] s1_r;
  logic [3:0] s0Nxt;
  logic [3:0] s1Nxt;
  logic [3:0] word [RS_N];
  logic errFound;
  logic lastSym;
  logic [3:0] aPow;

  assign s0Nxt = s0_r ^ sym;
  assign s1Nxt = gfMul(s1_r, GF_ALPHA) ^ sym;
  assign lastSym = symValid && (cnt_r == 4'(RS_N - 1));

  // single symbol correction from the two syndromes
  always_comb begin
    aPow = 4'h1;
    errFound = 1'b0;
    for (int i = 0; i < RS_N; i++) word[i] = (i == RS_N - 1) ? sym : sym_r[i];
    for (int p = 0; p < RS_N; p++) begin
      if (!errFound && s0Nxt != 4'h0 && gfMul(s0Nxt, aPow) == s1Nxt) begin
        errFound = 1'b1;
        word[RS_N-1-p] = word[RS_N-1-p] ^ s0Nxt;
      end
      aPow = gfMul(aPow, GF_ALPHA);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || flush || lastSym) begin
      cnt_r <= 4'h0;
      s0_r <= 4'h0;
      s1_r <= 4'h0;
    end else if (symValid) begin
      sym_r[cnt_r] <= sym;
      cnt_r <= cnt_r + 4'h1;
      s0_r <= s0Nxt;
      s1_r <= s1Nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wordValid <= 1'b0;
      wordData <= '0;
      corrected <= 1'b0;
      uncorrectable <= 1'b0;
    end else begin
      wordValid <= lastSym;
      corrected <= lastSym && errFound;
      // a partial codeword at the end symbol cannot be checked
      uncorrectable <= (lastSym && !errFound && (s0Nxt != 4'h0 || s1Nxt != 4'h0))
                       || (flush && cnt_r != 4'h0);
      if (lastSym) begin
        for (int i = 0; i < RS_K; i++) wordData[i*RS_SYM_W +: RS_SYM_W] <= word[i];
      end
    end
  end
endmodule // mlk_rs_dec
`default_nettype wire

// ---- mlk_sink_rx.sv ----
`default_nettype none
module mlk_sink_rx
  import mlk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkSymbolClock,
  input wire mlk_lanes_t laneIn,
  input wire logic [2:0] laneCount,
  input wire logic [MN_SHIFT_W-1:0] mnShift,
  output mlk_attr_t attr,
  output logic [MN_W-1:0] mvidFull,
  output logic [7:0] verticalBlankIdentifier,
  output logic [7:0] maudLow,
  output logic syncMode,
  output logic pixValid,
  output logic [LANES-1:0] pixMask,
  output mlk_pixels_t pix,
  output logic pixUnsupported,
  output logic secWordValid,
  output logic [RS_K*RS_SYM_W-1:0] secWord,
  output logic secCorrected,
  output logic secBad,
  output logic strmTick
);
  typedef enum {ST_ACTIVE, ST_VBID, ST_MVID, ST_MAUD, ST_BLANK, ST_SS, ST_ATTR, ST_SEC} mlk_st_t;

  function automatic int laneDelay(input int k, input logic [2:0] n);
    return (k < int'(n)) ? SKEW_SYMS * (int'(n) - 1 - k) : 0;
  endfunction

  logic [SYNC_STAGES-1:0] clkSync_r;
  logic clkLevel_r;
  logic symEdge;
  mlk_lanes_t laneS1_r;
  mlk_lanes_t laneS2_r;
  mlk_lanes_t laneS3_r;
  mlk_sym_t hist_r [LANES][DESKEW_DEPTH];
  mlk_lanes_t algn_r;
  logic algnStb_r;
  mlk_st_t st_r;
  logic [3:0] idx_r;
  mlk_attr_t cand_r;
  mlk_attr_t candPrev_r;
  logic stuffing_r;
  logic [1:0] phase_r;
  mlk_pixels_t pixAcc_r;
  logic secHi_r;
  logic [3:0] secHiNib_r;
  logic [ACC_W-1:0] acc_r;
  logic [7:0] voted;
  logic [7:0] l0;
  logic ctl;
  logic isBs;
  logic isBe;
  logic secFeed;
  logic secEnd;
  logic [RS_SYM_W-1:0] secSym;
  logic [ACC_W-1:0] mEff;
  logic [ACC_W-1:0] nEff;
  logic [ACC_W-1:0] accSum;

  // link clock level accepted once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clkSync_r <= '0;
      clkLevel_r <= 1'b0;
    end else begin
      clkSync_r <= {clkSync_r[SYNC_STAGES-2:0], linkSymbolClock};
      if (clkSync_r[2] == clkSync_r[1]) clkLevel_r <= clkSync_r[2];
    end
  end
  assign symEdge = (clkSync_r[2] == clkSync_r[1]) && clkSync_r[2] && !clkLevel_r;

  // lane data goes through the same three stages, so it lines up with the edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      laneS1_r <= '0;
      laneS2_r <= '0;
      laneS3_r <= '0;
    end else begin
      laneS1_r <= laneIn;
      laneS2_r <= laneS1_r;
      laneS3_r <= laneS2_r;
    end
  end

  // lower lanes wait for the highest active lane
  always_ff @(posedge core_clk) begin
    if (rst) begin
      algn_r <= '0;
      algnStb_r <= 1'b0;
      for (int k = 0; k < LANES; k++)
        for (int d = 0; d < DESKEW_DEPTH; d++) hist_r[k][d] <= '0;
    end else begin
      algnStb_r <= symEdge;
      if (symEdge) begin
        for (int k = 0; k < LANES; k++) begin
          hist_r[k][0] <= laneS3_r[k];
          for (int d = 1; d < DESKEW_DEPTH; d++) hist_r[k][d] <= hist_r[k][d-1];
          if (k >= int'(laneCount)) algn_r[k] <= '0;
          else if (laneDelay(k, laneCount) == 0) algn_r[k] <= laneS3_r[k];
          else algn_r[k] <= hist_r[k][laneDelay(k, laneCount) - 1];
        end
      end
    end
  end

  assign voted = mlk_vote(algn_r, laneCount);
  assign l0 = algn_r[0].data;
  assign ctl = algn_r[0].isCtrl;
  assign isBs = algnStb_r && ctl && l0 == SYM_BS;
  assign isBe = algnStb_r && ctl && l0 == SYM_BE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= ST_BLANK;
      idx_r <= 4'h0;
    end else if (isBs) begin
      st_r <= ST_VBID;
    end else if (isBe) begin
      st_r <= ST_ACTIVE;
    end else if (algnStb_r) begin
      case (st_r)
        ST_VBID: st_r <= ST_MVID;
        ST_MVID: st_r <= ST_MAUD;
        ST_MAUD: st_r <= ST_BLANK;
        ST_BLANK: if (ctl && l0 == SYM_SS) st_r <= ST_SS;
        ST_SS: begin
          idx_r <= 4'h0;
          if (ctl && l0 == SYM_SS) st_r <= ST_ATTR;
          else if (ctl && l0 == SYM_SE) st_r <= ST_BLANK;
          else st_r <= ST_SEC;
        end
        ST_ATTR, ST_SEC: begin
          if (ctl && l0 == SYM_SE) st_r <= ST_BLANK;
          else if (idx_r != 4'hF) idx_r <= idx_r + 4'h1;
        end
        default: st_r <= ST_ACTIVE;
      endcase
    end
  end

  // identifier and time stamp low bytes after blank start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      verticalBlankIdentifier <= 8'h00;
      maudLow <= 8'h00;
      mvidFull <= '0;
    end else if (algnStb_r && !ctl) begin
      if (st_r == ST_VBID) verticalBlankIdentifier <= voted;
      if (st_r == ST_MAUD) maudLow <= voted;
      if (st_r == ST_MVID) begin
        mvidFull <= {mvidFull[MN_W-1:8] + ((voted < mvidFull[7:0]) ? 16'h0001 : 16'h0000),
                     voted};
      end else if (st_r == ST_ATTR && idx_r == ATTR_MVID_LO) begin
        mvidFull <= {cand_r.mvid[MN_W-1:8], voted};
      end
    end
  end

  // attribute rows; only the four-lane layout places N and misc on lane three
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cand_r <= '{mvid: '0, nvid: N_ASYNC, misc: MISC_RESET};
      candPrev_r <= '{mvid: '0, nvid: N_ASYNC, misc: MISC_RESET};
      attr <= '{mvid: '0, nvid: N_ASYNC, misc: MISC_RESET};
    end else if (algnStb_r && st_r == ST_ATTR) begin
      if (ctl && l0 == SYM_SE) begin
        if (idx_r >= ATTR_LEN) begin
          candPrev_r <= cand_r;
          attr.mvid <= cand_r.mvid;
          // a single corrupted copy never replaces the held constants
          if (cand_r.nvid == candPrev_r.nvid && cand_r.misc == candPrev_r.misc) begin
            attr.nvid <= cand_r.nvid;
            attr.misc <= cand_r.misc;
          end
        end
      end else begin
        case (idx_r)
          ATTR_MVID_HI: cand_r.mvid[23:16] <= voted;
          ATTR_MVID_MID: cand_r.mvid[15:8] <= voted;
          ATTR_MVID_LO: cand_r.mvid[7:0] <= voted;
          ATTR_NVID_HI: cand_r.nvid[23:16] <= algn_r[NVID_LANE].data;
          ATTR_NVID_MID: cand_r.nvid[15:8] <= algn_r[NVID_LANE].data;
          ATTR_NVID_LO: cand_r.nvid[7:0] <= algn_r[NVID_LANE].data;
          ATTR_MISC: cand_r.misc <= algn_r[NVID_LANE].data;
          default: cand_r <= cand_r;
        endcase
      end
    end
  end

  assign syncMode = attr.misc[MISC_SYNC_BIT];
  assign pixUnsupported = attr.misc[MISC_DEPTH_LSB +: 3] != DEPTH_8BPC
                          || attr.misc[MISC_FMT_LSB +: 2] != FMT_RGB;

  // stuffing dropped between stuff start and stuff end; 8-bit RGB, one pixel per lane
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stuffing_r <= 1'b0;
      phase_r <= 2'h0;
      pixAcc_r <= '0;
      pix <= '0;
      pixValid <= 1'b0;
      pixMask <= '0;
    end else begin
      pixValid <= 1'b0;
      if (isBe || isBs) begin
        stuffing_r <= 1'b0;
        phase_r <= 2'h0;
      end else if (algnStb_r && st_r == ST_ACTIVE) begin
        if (ctl && l0 == SYM_FS) stuffing_r <= 1'b1;
        else if (ctl && l0 == SYM_FE) stuffing_r <= 1'b0;
        else if (!ctl && !stuffing_r) begin
          for (int k = 0; k < LANES; k++) begin
            if (phase_r == 2'h0) pixAcc_r[k].red <= algn_r[k].data;
            if (phase_r == 2'h1) pixAcc_r[k].green <= algn_r[k].data;
            if (phase_r == 2'h2) begin
              pix[k] <= '{red: pixAcc_r[k].red, green: pixAcc_r[k].green,
                          blue: algn_r[k].data};
              pixMask[k] <= k < int'(laneCount);
            end
          end
          phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
          pixValid <= phase_r == 2'h2 && !pixUnsupported;
        end
      end
    end
  end

  // lane 0 packet bytes go out as two nibble symbols, low nibble first
  assign secFeed = (algnStb_r && !ctl && (st_r == ST_SS || st_r == ST_SEC)) || secHi_r;
  assign secSym = secHi_r ? secHiNib_r : l0[3:0];
  assign secEnd = algnStb_r && ctl && l0 == SYM_SE && st_r == ST_SEC;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      secHi_r <= 1'b0;
      secHiNib_r <= 4'h0;
    end else begin
      secHi_r <= algnStb_r && !ctl && (st_r == ST_SS || st_r == ST_SEC);
      secHiNib_r <= l0[7:4];
    end
  end

  mlk_rs_dec rsDec (
    .core_clk(core_clk),
    .rst(rst),
    .symValid(secFeed),
    .sym(secSym),
    .flush(secEnd),
    .wordValid(secWordValid),
    .wordData(secWord),
    .corrected(secCorrected),
    .uncorrectable(secBad)
  );

  // stream clock from M/N: add M each link symbol, one tick per N drained
  assign mEff = ACC_W'((syncMode ? attr.mvid : mvidFull) >> mnShift);
  assign nEff = ACC_W'(attr.nvid >> mnShift);
  // one M per symbol; no multi-block accumulation, so precision stays that of one M
  assign accSum = acc_r + (symEdge ? mEff : '0);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_r <= '0;
      strmTick <= 1'b0;
    end else if (nEff != '0 && accSum >= nEff) begin
      acc_r <= accSum - nEff;
      strmTick <= 1'b1;
    end else begin
      acc_r <= (nEff == '0) ? '0 : accSum;
      strmTick <= 1'b0;
    end
  end
endmodule // mlk_sink_rx
`default_nettype wire

// ---- mlk_sink_rx_chk.sv ----
`default_nettype none
module mlk_sink_rx_chk
  import mlk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] laneCount,
  input wire mlk_attr_t attr,
  input wire logic [MN_W-1:0] mvidFull,
  input wire logic syncMode,
  input wire logic pixValid,
  input wire logic [LANES-1:0] pixMask,
  input wire logic pixUnsupported,
  input wire logic secWordValid,
  input wire logic secCorrected,
  input wire logic secBad
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a pixel group or codeword spans many link symbols, so pulses stay far apart
  sequence pixQuiet; !pixValid [*8]; endsequence
  sequence secQuiet; !secWordValid [*8]; endsequence
  reset_vals_a: assert property (disable iff (1'b0)
    rst |=> attr == {24'h000000, N_ASYNC, MISC_RESET} && mvidFull == 24'h000000
    && !pixValid && !secWordValid && !secBad) else $error("outputs off reset values");
  sync_bit_a: assert property (syncMode == attr.misc[MISC_SYNC_BIT])
    else $error("sync mode differs from misc bit");
  unsup_fmt_a: assert property (pixUnsupported == (attr.misc[7:5] != DEPTH_8BPC
    || attr.misc[2:1] != FMT_RGB)) else $error("unsupported flag wrong");
  pix_gate_a: assert property (pixUnsupported |-> !pixValid)
    else $error("pixel out in unsupported format");
  pix_mask_a: assert property (pixValid |-> pixMask == (laneCount == 3'h4 ? 4'hF :
    laneCount == 3'h2 ? 4'h3 : 4'h1)) else $error("pixel lane mask wrong");
  pix_gap_a: assert property (pixValid |=> pixQuiet)
    else $error("pixel pulses too close");
  sec_gap_a: assert property (secWordValid |=> secQuiet)
    else $error("codeword pulses too close");
  sec_fix_a: assert property (secCorrected |-> secWordValid && !secBad)
    else $error("correction flag without good word");
  mvid_carry_a: assert property ($changed(mvidFull[7:0]) &&
    mvidFull[7:0] < $past(mvidFull[7:0]) |-> mvidFull[23:8] == $past(mvidFull[23:8]) + 16'h0001)
    else $error("video M carry lost");
endmodule // mlk_sink_rx_chk
bind mlk_sink_rx mlk_sink_rx_chk chk (.core_clk, .rst, .laneCount, .attr, .mvidFull, .syncMode,
  .pixValid, .pixMask, .pixUnsupported, .secWordValid, .secCorrected, .secBad);
`default_nettype wire

// ---- mlk_src_model.sv ----
`default_nettype none
module mlk_src_model
  import mlk_pkg::*;
(
  input wire logic core_clk,
  input wire logic [2:0] laneCount,
  output logic linkSymbolClock,
  output mlk_lanes_t laneIn
);
  timeunit 1ns;
  timeprecision 100ps;
  mlk_lanes_t rowQ [$];
  mlk_lanes_t hist [DESKEW_DEPTH:0];
  mlk_lanes_t row;
  logic lscD;
  logic [7:0] fill;
  initial begin
    linkSymbolClock = 1'b0;
    laneIn = '0;
    lscD = 1'b0;
    fill = 8'h00;
    for (int i = 0; i <= DESKEW_DEPTH; i++) hist[i] = '0;
  end
  // main link clock runs free, unrelated in phase to core_clk
  always #62.5 linkSymbolClock = ~linkSymbolClock;
  // lanes move just after a falling link edge, far from the sampling edge
  always @(posedge core_clk) begin
    lscD <= linkSymbolClock;
    if (lscD && !linkSymbolClock) begin
      row = {LANES{1'b0, fill}};
      if (rowQ.size() > 0) row = rowQ.pop_front();
      fill <= fill + 8'h01;
      for (int i = DESKEW_DEPTH; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = row;
      // lane 0 leads, each higher lane trails the one below by two symbols
      for (int k = 0; k < LANES; k++)
        if (k < laneCount) laneIn[k] <= hist[SKEW_SYMS * k][k];
        else laneIn[k] <= ~laneIn[k];
    end
  end
endmodule // mlk_src_model
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench import mlk_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, linkSymbolClock, syncMode, pixValid, pixUnsupported, strmTick;
  logic secWordValid, secCorrected, secBad;
  logic [2:0] laneCount;
  logic [MN_SHIFT_W-1:0] mnShift;
  mlk_lanes_t laneIn;
  mlk_attr_t attr;
  logic [MN_W-1:0] mvidFull;
  logic [7:0] verticalBlankIdentifier, maudLow;
  logic [LANES-1:0] pixMask;
  mlk_pixels_t pix;
  logic [RS_K*RS_SYM_W-1:0] secWord;
  int num_errors = 0;
  int check_count = 0;
  int t;
  logic [31:0] seed = 32'h84F5;
  logic [99:0] pixQ [$];
  logic [53:0] secQ [$];
  logic [95:0] ep;
  mlk_lanes_t r;
  localparam logic [71:0] L0 = {24'h000010, 48'h0};
  localparam logic [71:0] L3 = {24'h000010, 24'h000040, 8'h21, 16'h0};
  localparam logic [71:0] LA = {24'h004000, N_ASYNC, 8'h22, 16'h0};
  mlk_sink_rx DUT (.core_clk, .rst, .linkSymbolClock, .laneIn, .laneCount, .mnShift, .attr,
    .mvidFull, .verticalBlankIdentifier, .maudLow, .syncMode, .pixValid, .pixMask, .pix,
    .pixUnsupported, .secWordValid, .secWord, .secCorrected, .secBad, .strmTick);
  mlk_src_model src (.core_clk, .laneCount, .linkSymbolClock, .laneIn);
  always #4 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic mlk_lanes_t all(input logic c, input logic [7:0] d);
    return {LANES{c, d}};
  endfunction
  task automatic check(input logic [99:0] seen, input logic [99:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // stream ticks over 64 link symbols, M and N both shifted by s
  task automatic ticks(input int s, input int lo, input int hi);
    mnShift <= MN_SHIFT_W'(s);
    repeat (20) @(posedge core_clk);
    t = 0;
    fork
      repeat (64) @(posedge linkSymbolClock);
      forever @(posedge core_clk) t += int'(strmTick);
    join_any
    disable fork;
    check(100'(t >= lo && t <= hi), 100'(1'b1));
  endtask
  task automatic send(input mlk_lanes_t v);
    src.rowQ.push_back(v);
  endtask
  // flush the queue, then the skew pipeline and output latency
  task automatic drain;
    for (int i = 0; i < 5000 && src.rowQ.size() > 0; i++) @(posedge core_clk);
    repeat (DESKEW_DEPTH + 2) @(posedge linkSymbolClock);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic reset_dut(input logic [2:0] lc);
    rst <= 1'b1;
    laneCount <= lc;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    drain;
  endtask
  // one bad copy in the identifier and the audio byte, none in the M byte; the vote must outweigh it
  task automatic line(input logic [7:0] v, input logic [7:0] m, input logic [7:0] a);
    send(all(1'b1, SYM_BS));
    r = all(1'b0, v);
    r[2].data = ~v;
    send(r);
    send(all(1'b0, m));
    r = all(1'b0, a);
    r[1].data = ~a;
    send(r);
  endtask
  task automatic attr_blk(input logic [71:0] a0, input logic [71:0] a3);
    send(all(1'b1, SYM_SS));
    send(all(1'b1, SYM_SS));
    for (int i = 0; i < ATTR_LEN; i++) begin
      r = all(1'b0, a0[71-8*i -: 8]);
      r[NVID_LANE].data = a3[71-8*i -: 8];
      if (i == 0) r[0].data = ~a0[71:64];
      send(r);
    end
    send(all(1'b1, SYM_SE));
  endtask
  always @(posedge core_clk) begin
    if (pixValid === 1'b1)
      check({pixMask, pix}, pixQ.size() ? pixQ.pop_front() : {100{1'bx}});
    if (secWordValid === 1'b1 || secBad === 1'b1)
      check(100'({secWord, secCorrected, secBad}),
        secQ.size() ? 100'(secQ.pop_front()) : {100{1'bx}});
  end
  initial begin
    #300us;
    num_errors++;
    end_of_test;
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    laneCount = 3'h4;
    mnShift = '0;
    reset_dut(3'h4);
    check(100'({attr, mvidFull}), 100'({24'h000000, N_ASYNC, MISC_RESET, 24'h000000}));
    for (int j = 0; j < 2; j++) begin
      reset_dut(j ? 3'h2 : 3'h4);
      for (int n = 0; n < 2; n++) begin
        seed = lfsr(seed);
        line(seed[7:0], n ? 8'h10 : 8'hF0, seed[15:8]);
        drain;
        check(100'(verticalBlankIdentifier), 100'(seed[7:0]));
        check(100'(maudLow), 100'(seed[15:8]));
        check(100'(mvidFull), 100'(n ? 24'h000110 : 24'h0000F0));
      end
    end
    reset_dut(3'h4);
    line(8'h00, 8'h00, 8'h00);
    attr_blk(L0, L3);
    drain;
    check(100'(attr), 100'({L0[71:48], N_ASYNC, MISC_RESET}));
    attr_blk(L0, L3);
    drain;
    check(100'(attr), 100'(L3[71:16]));
    check(100'(syncMode), 100'(1'b1));
    for (int s = 0; s < 3; s += 2) ticks(s, 15, 17);
    send(all(1'b1, SYM_BE));
    for (int c = 0; c < 3; c++) begin
      seed = lfsr(seed);
      r = all(1'b0, 8'h00);
      for (int k = 0; k < LANES; k++) begin
        r[k].data = seed[8*k +: 8];
        ep[24*k + 8*(2-c) +: 8] = seed[8*k +: 8];
      end
      send(r);
      if (c == 0) begin
        send(all(1'b1, SYM_FS));
        send(all(1'b0, 8'hA5));
        send(all(1'b1, SYM_FE));
      end
    end
    pixQ.push_back({4'hF, ep});
    line(8'h00, 8'h00, 8'h00);
    // all-zero data is a valid codeword; one flipped nibble must be repaired
    secQ.push_back({52'h0, 1'b1, 1'b0});
    secQ.push_back({52'h0, 1'b0, 1'b0});
    secQ.push_back({52'h0, 1'b0, 1'b1});
    for (int p = 0; p < 2; p++) begin
      send(all(1'b1, SYM_SS));
      for (int i = 0; i < (p ? 1 : 15); i++) send(all(1'b0, (i == 0 && p == 0) ? 8'h05 : 8'h00));
      send(all(1'b1, SYM_SE));
    end
    drain;
    check(100'(pixQ.size() + secQ.size()), 100'(0));
    // asynchronous mode, unsupported format: pixels must stay gated while active
    reset_dut(3'h4);
    attr_blk(LA, LA);
    attr_blk(LA, LA);
    send(all(1'b1, SYM_BE));
    drain;
    check(100'(attr), 100'(LA[71:16]));
    check(100'(mvidFull), 100'(LA[71:48]));
    check(100'({syncMode, pixUnsupported}), 100'(2'b01));
    ticks(4, 31, 33);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
